//--- dv/stpc_host.sv
// host model: serial frames on a link clock and step pulses
`timescale 1ns/1ps
module stpc_host (
   // system clock
   input wire logic sys_clk,
   // serial link
   output logic     ser_clk,
   output logic     select_low_input,
   output logic     serial_in_pin,
   input wire logic serial_out_o,
   input wire logic serial_out_oe,
   // step clock
   output logic     step_in
);
   wire do_line = serial_out_oe ? serial_out_o : 1'bz;
   initial begin
      ser_clk = 1'b0;
      select_low_input = 1'b1;
      serial_in_pin = 1'b0;
      step_in = 1'b0;
   end
   // n bits msb first; link clock runs only inside the frame
   task automatic xfer(input logic [15:0] wd, input int n, output logic [15:0] rd);
      rd = 'x;
      @(negedge sys_clk);
      select_low_input = 1'b0;
      repeat (6) @(negedge sys_clk);
      #1.7;
      for (int k = 0; k < n; k++) begin
         serial_in_pin = wd[15-k];
         #3;
         ser_clk = 1'b1;
         rd = {rd[14:0], do_line};
         #3;
         ser_clk = 1'b0;
      end
      @(negedge sys_clk);
      select_low_input = 1'b1;
      serial_in_pin = 1'b0;
      // clock stays still while the word is taken over
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic step();
      @(negedge sys_clk);
      step_in = 1'b1;
      repeat (4) @(negedge sys_clk);
      step_in = 1'b0;
      repeat (14) @(negedge sys_clk);
   endtask
endmodule

//--- dv/stpc_sva.sv
// port checks of the stepper control top
`timescale 1ns/1ps
module stpc_sva (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rstn,
   // pins and outputs
   input wire logic       select_low_input,
   input wire logic       step_in,
   input wire logic       enable_in,
   input wire logic       ovc_a,
   input wire logic       serial_out_oe,
   input wire logic       active_o,
   input wire logic       bridge_on_a,
   input wire logic       bridge_on_b,
   input wire logic [1:0] decay_a,
   input wire logic [1:0] decay_b,
   input wire logic [7:0] limit_a,
   input wire logic       pwm_mon_o,
   input wire logic       pwm_mon_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   logic [9:0] ovc_cnt_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ovc_cnt_q <= 10'h000;
      end else if (!ovc_a) begin
         ovc_cnt_q <= 10'h000;
      end else if (ovc_cnt_q != 10'h3ff) begin
         ovc_cnt_q <= ovc_cnt_q + 10'h001;
      end
   end
   a_dout_float_sel: assert property (select_low_input |-> !serial_out_oe)
      else $error("data out driven while deselected");
   a_standby_no_drive: assert property (!enable_in && !active_o |-> !serial_out_oe && !pwm_mon_oe)
      else $error("output driven in standby");
   a_standby_outs_off: assert property (!active_o [*3] |->
      !bridge_on_a && !bridge_on_b && limit_a == 8'h00)
      else $error("bridge or limit alive in standby");
   a_enable_goes_active: assert property (enable_in [*8] |-> active_o)
      else $error("enable did not activate");
   a_disable_goes_idle: assert property (!enable_in [*8] |-> !active_o)
      else $error("enable low did not enter standby");
   a_pwm_mon_follow: assert property ($changed(bridge_on_a) |->
      ##[0:1] (pwm_mon_o == bridge_on_a))
      else $error("pwm monitor does not follow bridge a");
   a_step_restart_pwm: assert property ($rose(step_in) && active_o && !ovc_a |->
      ##[1:12] bridge_on_a)
      else $error("step did not start a pwm cycle");
   a_auto_decay_resolved: assert property (decay_a != 2'h3 && decay_b != 2'h3)
      else $error("unresolved decay mode in effect");
   a_ovc_cut_off: assert property (ovc_cnt_q > 10'(stpc_pkg::ISC_CYC + 8) |-> !bridge_on_a)
      else $error("bridge a on during long overcurrent");
endmodule
bind stpc_top stpc_sva stpc_sva_i (
   .sys_clk(sys_clk), .rstn(rstn), .select_low_input(select_low_input), .step_in(step_in),
   .enable_in(enable_in), .ovc_a(ovc_a), .serial_out_oe(serial_out_oe), .active_o(active_o),
   .bridge_on_a(bridge_on_a), .bridge_on_b(bridge_on_b), .decay_a(decay_a),
   .decay_b(decay_b), .limit_a(limit_a), .pwm_mon_o(pwm_mon_o), .pwm_mon_oe(pwm_mon_oe)
);

//--- dv/stpc_top_test.sv
// self-checking bench of the stepper control top
`timescale 1ns/1ps
module stpc_top_test;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        enable_in = 1'b0;
   logic        ovc_a = 1'b0;
   logic        hit_on = 1'b1;
   logic        cur_hit_a = 1'b0;
   logic        cur_hit_b = 1'b0;
   logic        tsd_in = 1'b0;
   wire         ser_clk, select_low_input, serial_in_pin, step_in, serial_out_o;
   wire         serial_out_oe, active_o, bridge_on_a, bridge_on_b, pwm_mon_o, pwm_mon_oe;
   wire  [1:0]  decay_a, decay_b;
   wire  [7:0]  limit_a, limit_b;
   wire         sign_a, sign_b;
   logic [15:0] rd;
   int          fail_count = 0;
   int          n_tests = 0;
   int          pos = 0;
   always #5 sys_clk = ~sys_clk;
   // comparator stand-in: limit reached half a cycle after the bridge on output rises
   always @(negedge sys_clk) begin
      cur_hit_a <= hit_on & bridge_on_a;
      cur_hit_b <= hit_on & bridge_on_b;
   end
   stpc_top #(.PWM_CYC(64)) stpc_top_i (
      .sys_clk(sys_clk), .rstn(rstn), .ser_clk(ser_clk), .select_low_input(select_low_input),
      .serial_in_pin(serial_in_pin), .serial_out_o(serial_out_o),
      .serial_out_oe(serial_out_oe), .step_in(step_in), .enable_in(enable_in),
      .cur_hit_a(cur_hit_a), .cur_hit_b(cur_hit_b), .ovc_a(ovc_a), .ovc_b(1'b0),
      .tsd_in(tsd_in), .active_o(active_o), .bridge_on_a(bridge_on_a),
      .bridge_on_b(bridge_on_b), .sign_a(sign_a), .sign_b(sign_b),
      .decay_a(decay_a), .decay_b(decay_b),
      .limit_a(limit_a), .limit_b(limit_b), .pwm_mon_o(pwm_mon_o), .pwm_mon_oe(pwm_mon_oe));
   stpc_host stpc_host_i (
      .sys_clk(sys_clk), .ser_clk(ser_clk), .select_low_input(select_low_input),
      .serial_in_pin(serial_in_pin), .serial_out_o(serial_out_o),
      .serial_out_oe(serial_out_oe), .step_in(step_in));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic results();
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [12:0] d);
      stpc_host_i.xfer({a, d}, 16, rd);
   endtask
   // a command word with no clear bits fetches the status and also zeroes the stall threshold
   task automatic rdst();
      stpc_host_i.xfer(16'he000, 16, rd);
   endtask
   function automatic logic [4:0] ent(input int k);
      return 5'(3 * k + 2);
   endfunction
   function automatic logic [4:0] dac(input int p, input int ph);
      int i;
      i = p % 8;
      return ent((((p / 8) % 2) != ph) ? i : 8 - i);
   endfunction
   task automatic step_chk(input int d, input logic [1:0] da, input logic [1:0] db);
      stpc_host_i.step();
      pos = (pos + d + 32) % 32;
      chk({limit_a, limit_b}, {8'(dac(pos, 0)) * 8'h02, 8'(dac(pos, 1)) * 8'h02}, "limits");
      chk({12'h000, decay_a, decay_b}, {12'h000, da, db}, "decay");
      chk({14'h0000, sign_a, sign_b}, 16'({pos[4] ^ pos[3], pos[4]}), "signs");
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      enable_in = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk({14'h0000, active_o, serial_out_oe}, 16'h0002, "active, out floating");
      wr(stpc_pkg::A_SCALE, 13'h0001);
      for (int j = 0; j < 5; j++) begin
         wr(3'(stpc_pkg::A_LUT0 + j), {3'h0, (j < 4 ? ent(2*j+1) : 5'h00), ent(2*j)});
      end
      for (int m = 0; m < 4; m++) begin
         wr(stpc_pkg::A_CTRL, 13'((m << 3) | (m << 1)));
         step_chk(8 >> m, (m == 3) ? 2'h0 : 2'(m), (m == 3) ? 2'h1 : 2'(m));
      end
      wr(stpc_pkg::A_CTRL, 13'h001f);
      step_chk(-1, 2'h1, 2'h0);
      rdst();
      chk(rd, {6'h00, 5'(pos), dac(pos, 0)}, "status word");
      stpc_host_i.xfer(16'h0040, 15, rd);
      chk({15'h0000, pwm_mon_oe}, 16'h0001, "short frame taken");
      wr(stpc_pkg::A_CTRL, 13'h0020);
      chk({15'h0000, pwm_mon_oe}, 16'h0000, "monitor not floating");
      wr(stpc_pkg::A_CTRL, 13'h0000);
      chk({15'h0000, pwm_mon_oe}, 16'h0001, "monitor not back");
      wr(stpc_pkg::A_CMD, 13'h0100);
      wr(stpc_pkg::A_CTRL, 13'h0040);
      repeat (130) @(negedge sys_clk);
      rdst();
      chk(rd & 16'h0400, 16'h0400, "stall flag");
      wr(stpc_pkg::A_CMD, 13'h0008);
      hit_on = 1'b0;
      repeat (20 * 64) @(negedge sys_clk);
      hit_on = 1'b1;
      rdst();
      chk(rd & 16'hc000, 16'hc000, "open load");
      wr(stpc_pkg::A_CMD, 13'h0010);
      rdst();
      chk(rd & 16'hc000, 16'h0000, "open load clear");
      // a pulse under the filter time must leave no flag
      for (int t = 0; t < 2; t++) begin
         {ovc_a, tsd_in} = 2'h3;
         repeat (t ? 3300 : 300) @(negedge sys_clk);
         {ovc_a, tsd_in} = 2'h0;
         rdst();
         chk(rd & 16'h1800, t ? 16'h1800 : 16'h0000, "fault flags");
      end
      wr(stpc_pkg::A_CMD, 13'h0005);
      rdst();
      chk(rd & 16'h1800, 16'h0000, "fault clear");
      enable_in = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk({8'h00, limit_a}, 16'h0000, "standby limit");
      enable_in = 1'b1;
      repeat (10) @(negedge sys_clk);
      rdst();
      chk(rd, 16'h0000, "cleared status");
      results();
   end
   initial begin
      #200_000;
      fail_count++;
      results();
   end
endmodule

//--- logic/stpc_pkg.sv
// shared constants and types of the stepper step and serial control logic
package stpc_pkg;
   // --------------------------------------------------------------
   // clock and times
   // --------------------------------------------------------------
   localparam int unsigned SYS_MHZ = 100;
   localparam int unsigned GL_US   = 32;
   localparam int unsigned ISC_US  = 4;
   localparam int unsigned GL_CYC  = GL_US * SYS_MHZ;
   localparam int unsigned ISC_CYC = ISC_US * SYS_MHZ;
   localparam logic [3:0]  OL_MISS = 4'hf;
   // --------------------------------------------------------------
   // serial frame
   // --------------------------------------------------------------
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned ADDR_LO = 13;
   localparam logic [4:0]  CNT_ONE = 5'h01;
   localparam logic [4:0]  CNT_FUL = 5'h10;
   localparam logic [4:0]  CNT_SAT = 5'h11;
   // --------------------------------------------------------------
   // register addresses and fields
   // --------------------------------------------------------------
   localparam logic [2:0]  A_CTRL  = 3'h0;
   localparam logic [2:0]  A_SCALE = 3'h1;
   localparam logic [2:0]  A_LUT0  = 3'h2;
   localparam logic [2:0]  A_CMD   = 3'h7;
   localparam int unsigned B_DIR   = 0;
   localparam int unsigned B_MODE  = 1;
   localparam int unsigned B_DECAY = 3;
   localparam int unsigned B_PWMZ  = 5;
   localparam int unsigned B_STEN  = 6;
   localparam int unsigned CTRL_W  = 7;
   localparam int unsigned B_CLR   = 0;
   localparam int unsigned CLR_W   = 5;
   localparam int unsigned B_THR   = 8;
   localparam int unsigned THR_SH  = 4;
   localparam int unsigned LUT_N   = 9;
   localparam int unsigned LUT_W   = 5;
   localparam logic [3:0]  LUT_TOP = 4'h8;
   localparam int unsigned SCALE_W = 3;
   localparam int unsigned POS_W   = 5;
   localparam int unsigned LIM_W   = 8;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      DEC_SLOW  = 2'h0,
      DEC_FAST  = 2'h1,
      DEC_MIXED = 2'h2,
      DEC_AUTO  = 2'h3
   } stpc_decay_t;
   typedef enum logic [2:0] {
      PW_OFF = 3'b001,
      PW_ON  = 3'b010,
      PW_DEC = 3'b100
   } stpc_pwm_t;
endpackage

//--- logic/stpc_top.sv
// stepper driver digital control: serial port, step counter, table, pwm, faults
// Overview of operation
// [RULE1] each serial frame carries sixteen bits, most significant bit first
// [RULE2] serial activity only counts while select_low_input is low
// [RULE3] serial_out_pin floats whenever select_low_input is high
// [RULE4] only the serial clock shifts the serial shift register
// [RULE5] step clock moves the phase counter up or down by direction
// [RULE6] each step rising edge restarts the pwm cycle
// [RULE7] enable low holds standby: outputs off, all registers cleared (code: the serial receive counter and shift register keep their values)
// [RULE8] enable high brings the block into active operation
// [RULE9] pwm monitor follows the bridge a regulator on/off state
// [RULE10] a serial command floats the pwm monitor until re-enabled
// [RULE11] nine five-bit current table entries written over serial port
// [RULE12] three-bit full-scale setting scales the table current levels
// [RULE13] full, half, mini and micro step change counter-to-table mapping
// [RULE14] off-time decay is slow, fast, mixed or automatic
// [RULE15] automatic decay: slow when current rises, fast when it falls
// [RULE16] a detected stall ends the movement and switches drivers off
// [RULE17] each step loads two table entries into phase a and b levels
// [RULE18] diagnostic condition must persist 32 us before its flag sets
// [RULE19] overcurrent of 4 us latches a flag and stops that driver
// [RULE20] open load flagged after fifteen pwm cycles missing the limit
// [RULE21] sample data on rising serial clock, change output on falling
// [RULE22] act on a word only when exactly sixteen edges preceded deselect (code: a frame with no edges acts again on the previous word)
`timescale 1ns/1ps
module stpc_top #(
   parameter int unsigned PWM_CYC = 2000
) (
   // system
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   // serial port
   input  wire logic                     ser_clk,
   input  wire logic                     select_low_input,
   input  wire logic                     serial_in_pin,
   output logic                          serial_out_o,
   output logic                          serial_out_oe,
   // control pins
   input  wire logic                     step_in,
   input  wire logic                     enable_in,
   // analog feedback
   input  wire logic                     cur_hit_a,
   input  wire logic                     cur_hit_b,
   input  wire logic                     ovc_a,
   input  wire logic                     ovc_b,
   input  wire logic                     tsd_in,
   // bridge control
   output logic                          active_o,
   output logic                          bridge_on_a,
   output logic                          bridge_on_b,
   output logic                          sign_a,
   output logic                          sign_b,
   output logic [1:0]                    decay_a,
   output logic [1:0]                    decay_b,
   output logic [stpc_pkg::LIM_W-1:0]    limit_a,
   output logic [stpc_pkg::LIM_W-1:0]    limit_b,
   // pwm monitor
   output logic                          pwm_mon_o,
   output logic                          pwm_mon_oe
);

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   localparam int NS = 8;
   logic [1:0]    rst_q;
   logic          rst_n;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [NS-1:0] s3_q;
   logic [NS-1:0] pin_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   assign pin_raw = {tsd_in, ovc_b, ovc_a, cur_hit_b, cur_hit_a,
                     enable_in, step_in, select_low_input};

   // a change counts only once the second and third stage agree
   for (genvar i = 0; i < NS; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            pin_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
         end
      end
   end

   logic en;
   assign en       = pin_q[2];
   assign active_o = en; // [RULE8]

   // ---------------------------------------------------------------
   // serial clock domain
   // ---------------------------------------------------------------
   localparam int WW = stpc_pkg::WORD_W;
   logic              ser_arst_n;
   logic              frame_q;
   logic [4:0]        rx_cnt_q;
   logic [WW-1:0]     rx_sh_q;
   logic [3:0]        tx_idx_q;
   logic [WW-1:0]     tx_snap_q;

   // deselect restarts the frame; standby also clears the frame flag and transmit index
   assign ser_arst_n = rst_n & en & ~select_low_input; // [RULE2]

   always_ff @(posedge ser_clk or negedge ser_arst_n) begin
      if (!ser_arst_n) frame_q <= 1'b0;
      else frame_q <= 1'b1;
   end

   // counter keeps its value after deselect so the system side can judge
   always_ff @(posedge ser_clk or negedge rst_n) begin // [RULE4]
      if (!rst_n) begin
         rx_cnt_q <= 5'h00;
         rx_sh_q  <= '0;
      end else if (!select_low_input) begin // [RULE2]
         rx_sh_q <= {rx_sh_q[WW-2:0], serial_in_pin}; // [RULE1] [RULE21]
         if (!frame_q) rx_cnt_q <= stpc_pkg::CNT_ONE;
         else if (rx_cnt_q != stpc_pkg::CNT_SAT) rx_cnt_q <= rx_cnt_q + 5'h01;
      end
   end

   always_ff @(negedge ser_clk or negedge ser_arst_n) begin
      if (!ser_arst_n) tx_idx_q <= 4'h0;
      else tx_idx_q <= tx_idx_q + 4'h1; // [RULE21]
   end

   // snapshot is frozen for the whole frame, so no crossing hazard
   assign serial_out_o  = tx_snap_q[~tx_idx_q]; // [RULE1]
   assign serial_out_oe = ~select_low_input & en; // [RULE3]

   // ---------------------------------------------------------------
   // frame acceptance and register writes
   // ---------------------------------------------------------------
   logic                          cs_d_q;
   logic                          cs_rise;
   logic                          cs_fall;
   logic                          wr;
   logic [2:0]                    wr_addr;
   logic [stpc_pkg::CTRL_W-1:0]   ctrl_q;
   logic [stpc_pkg::SCALE_W-1:0]  scale_q;
   logic [stpc_pkg::LUT_W-1:0]    thr_q;
   logic [stpc_pkg::LUT_W-1:0]    lut_q [stpc_pkg::LUT_N];
   logic [stpc_pkg::CLR_W-1:0]    clr;
   logic [WW-1:0]                 status;

   assign cs_rise = pin_q[0] & ~cs_d_q;
   assign cs_fall = ~pin_q[0] & cs_d_q;
   // rx counter and word sit still while deselected
   assign wr      = cs_rise & (rx_cnt_q == stpc_pkg::CNT_FUL); // [RULE22]
   assign wr_addr = rx_sh_q[WW-1:stpc_pkg::ADDR_LO];
   assign clr     = (wr && wr_addr == stpc_pkg::A_CMD) ?
                    rx_sh_q[stpc_pkg::B_CLR +: stpc_pkg::CLR_W] : '0;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_d_q    <= 1'b0;
         tx_snap_q <= '0;
      end else begin
         cs_d_q <= pin_q[0];
         if (!en) tx_snap_q <= '0; // [RULE7]
         else if (cs_fall) tx_snap_q <= status;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= '0;
         scale_q <= '0;
         thr_q   <= '0;
         for (int e = 0; e < stpc_pkg::LUT_N; e++) lut_q[e] <= '0;
      end else if (!en) begin // [RULE7]
         ctrl_q  <= '0;
         scale_q <= '0;
         thr_q   <= '0;
         for (int e = 0; e < stpc_pkg::LUT_N; e++) lut_q[e] <= '0;
      end else if (wr) begin
         if (wr_addr == stpc_pkg::A_CTRL) ctrl_q <= rx_sh_q[stpc_pkg::CTRL_W-1:0]; // [RULE10]
         if (wr_addr == stpc_pkg::A_SCALE) scale_q <= rx_sh_q[stpc_pkg::SCALE_W-1:0]; // [RULE12]
         if (wr_addr == stpc_pkg::A_CMD) thr_q <= rx_sh_q[stpc_pkg::B_THR +: stpc_pkg::LUT_W];
         for (int e = 0; e < stpc_pkg::LUT_N; e++) begin
            if (wr_addr == stpc_pkg::A_LUT0 + 3'(e / 2))
               lut_q[e] <= rx_sh_q[(e % 2) * stpc_pkg::LUT_W +: stpc_pkg::LUT_W]; // [RULE11]
         end
      end
   end

   logic       dir;
   logic [1:0] mode;
   logic [1:0] dec_sel;
   assign dir     = ctrl_q[stpc_pkg::B_DIR];
   assign mode    = ctrl_q[stpc_pkg::B_MODE +: 2];
   assign dec_sel = ctrl_q[stpc_pkg::B_DECAY +: 2];

   // ---------------------------------------------------------------
   // fault filters: overcurrent a, overcurrent b, thermal shutdown
   // ---------------------------------------------------------------
   logic [2:0] flt_q;

   for (genvar f = 0; f < 3; f++) begin : g_flt
      localparam logic [11:0] LIM = (f == 2) ? 12'(stpc_pkg::GL_CYC - 1)
                                             : 12'(stpc_pkg::ISC_CYC - 1);
      logic [11:0] cnt_q;
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_q    <= '0;
            flt_q[f] <= 1'b0;
         end else if (!en) begin
            cnt_q    <= '0;
            flt_q[f] <= 1'b0;
         end else begin
            if (!pin_q[5+f]) cnt_q <= '0;
            else if (cnt_q != LIM) cnt_q <= cnt_q + 12'h001;
            // set wins over a clear in the same cycle
            if (pin_q[5+f] && cnt_q == LIM) flt_q[f] <= 1'b1; // [RULE18] [RULE19]
            else if (clr[f]) flt_q[f] <= 1'b0; // [RULE19]
         end
      end
   end

   // ---------------------------------------------------------------
   // step input, phase counter and table lookup
   // ---------------------------------------------------------------
   localparam int PW = stpc_pkg::POS_W;
   localparam int LW = stpc_pkg::LUT_W;
   logic          step_d_q;
   logic          step_go;
   logic          stall_q;
   logic [PW-1:0] pos_q;
   logic [PW-1:0] pos_d;
   logic [PW-1:0] inc;
   logic [3:0]    idx [2];
   logic [LW-1:0] dac_q [2];
   logic          up_q [2];
   logic          sgn_q [2];

   // a stalled motor ignores steps until software clears the stall
   assign step_go = pin_q[1] & ~step_d_q & ~stall_q; // [RULE16]
   assign inc     = PW'(1) << (2'h3 - mode); // [RULE13]
   assign pos_d   = dir ? pos_q - inc : pos_q + inc; // [RULE5]
   // quarter wave table: a follows cosine, b follows sine
   assign idx[0]  = pos_d[3] ? {1'b0, pos_d[2:0]}
                             : stpc_pkg::LUT_TOP - {1'b0, pos_d[2:0]};
   assign idx[1]  = pos_d[3] ? stpc_pkg::LUT_TOP - {1'b0, pos_d[2:0]}
                             : {1'b0, pos_d[2:0]};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_d_q <= 1'b0;
         pos_q    <= '0;
      end else if (!en) begin
         step_d_q <= 1'b0;
         pos_q    <= '0;
      end else begin
         step_d_q <= pin_q[1];
         if (step_go) pos_q <= pos_d; // [RULE5]
      end
   end

   // ---------------------------------------------------------------
   // pwm cycle timer
   // ---------------------------------------------------------------
   logic [11:0] pwm_cnt_q;
   logic        cyc_start;
   assign cyc_start = step_go | (pwm_cnt_q == 12'(PWM_CYC - 1)); // [RULE6]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) pwm_cnt_q <= '0;
      else if (!en || cyc_start) pwm_cnt_q <= '0;
      else pwm_cnt_q <= pwm_cnt_q + 12'h001;
   end

   // ---------------------------------------------------------------
   // per bridge regulator
   // ---------------------------------------------------------------
   stpc_pkg::stpc_pwm_t        st_q [2];
   logic                       ol_q [2];
   logic                       stl [2];
   logic                       on_q [2];
   logic [1:0]                 dec_q [2];
   logic [stpc_pkg::LIM_W-1:0] lim_q [2];

   for (genvar b = 0; b < 2; b++) begin : g_br
      logic        ok;
      logic [3:0]  miss_q;
      logic [11:0] ont_q;
      assign ok = ~flt_q[b] & ~flt_q[2] & ~stall_q; // [RULE19]
      // short on-time with the bridge running means the rotor is blocked
      assign stl[b] = cyc_start & (st_q[b] != stpc_pkg::PW_OFF) &
                      ctrl_q[stpc_pkg::B_STEN] & (thr_q != '0) &
                      (ont_q < (12'(thr_q) << stpc_pkg::THR_SH));

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            dac_q[b] <= '0;
            up_q[b]  <= 1'b0;
            sgn_q[b] <= 1'b0;
         end else if (!en) begin
            dac_q[b] <= '0;
            up_q[b]  <= 1'b0;
            sgn_q[b] <= 1'b0;
         end else if (step_go) begin
            dac_q[b] <= lut_q[idx[b]]; // [RULE17]
            up_q[b]  <= lut_q[idx[b]] > dac_q[b]; // [RULE15]
            sgn_q[b] <= (b == 0) ? (pos_d[4] ^ pos_d[3]) : pos_d[4];
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) st_q[b] <= stpc_pkg::PW_OFF;
         else if (!en || !ok) st_q[b] <= stpc_pkg::PW_OFF; // [RULE7]
         else if (cyc_start) st_q[b] <= stpc_pkg::PW_ON; // [RULE6]
         else begin
            unique case (st_q[b])
               stpc_pkg::PW_ON:  if (pin_q[3+b]) st_q[b] <= stpc_pkg::PW_DEC;
               stpc_pkg::PW_DEC: st_q[b] <= stpc_pkg::PW_DEC;
               stpc_pkg::PW_OFF: st_q[b] <= stpc_pkg::PW_OFF;
               default:          st_q[b] <= stpc_pkg::PW_OFF;
            endcase
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            miss_q <= '0;
            ol_q[b] <= 1'b0;
            ont_q  <= '0;
         end else if (!en) begin
            miss_q <= '0;
            ol_q[b] <= 1'b0;
            ont_q  <= '0;
         end else begin
            if (cyc_start) begin
               ont_q <= '0;
               if (st_q[b] == stpc_pkg::PW_ON && miss_q != stpc_pkg::OL_MISS)
                  miss_q <= miss_q + 4'h1;
               else if (st_q[b] == stpc_pkg::PW_DEC) miss_q <= '0;
            end else if (st_q[b] == stpc_pkg::PW_ON) begin
               ont_q <= ont_q + 12'h001;
            end
            if (miss_q == stpc_pkg::OL_MISS) ol_q[b] <= 1'b1; // [RULE20]
            else if (clr[4]) ol_q[b] <= 1'b0;
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            on_q[b]  <= 1'b0;
            dec_q[b] <= '0;
            lim_q[b] <= '0;
         end else if (!en) begin
            on_q[b]  <= 1'b0;
            dec_q[b] <= '0;
            lim_q[b] <= '0;
         end else begin
            on_q[b]  <= ok & (st_q[b] == stpc_pkg::PW_ON);
            lim_q[b] <= stpc_pkg::LIM_W'(dac_q[b]) *
                        stpc_pkg::LIM_W'({1'b0, scale_q} + 4'h1); // [RULE12]
            if (dec_sel == stpc_pkg::DEC_AUTO) // [RULE14]
               dec_q[b] <= up_q[b] ? stpc_pkg::DEC_SLOW
                                   : stpc_pkg::DEC_FAST; // [RULE15]
            else dec_q[b] <= dec_sel;
         end
      end
   end

   // ---------------------------------------------------------------
   // stall flag
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) stall_q <= 1'b0;
      else if (!en) stall_q <= 1'b0;
      else if (stl[0] | stl[1]) stall_q <= 1'b1; // [RULE16]
      else if (clr[3]) stall_q <= 1'b0;
   end

   // ---------------------------------------------------------------
   // outputs and status word
   // ---------------------------------------------------------------
   assign status = {ol_q[1], ol_q[0], flt_q[1], flt_q[0], flt_q[2],
                    stall_q, pos_q, dac_q[0]};

   assign bridge_on_a = on_q[0];
   assign bridge_on_b = on_q[1];
   assign sign_a      = sgn_q[0];
   assign sign_b      = sgn_q[1];
   assign decay_a     = dec_q[0];
   assign decay_b     = dec_q[1];
   assign limit_a     = lim_q[0];
   assign limit_b     = lim_q[1];
   assign pwm_mon_o   = on_q[0]; // [RULE9]
   assign pwm_mon_oe  = en & ~ctrl_q[stpc_pkg::B_PWMZ]; // [RULE10]

endmodule
